// ===== src/reset_filter_map.vh
// Summary of operation
// - Five-bit width field sets the filter count to field plus one, 1 to 32.
// - Unused bits of every register read zero and ignore writes.
// - Force-ROM field is initialised only by power-on reset, kept otherwise.
// - Either force-ROM bit set makes every later system reset boot from ROM.
// - Force value 00 has no effect; each set bit sets its boot-source bit.
// - Mode register captures the boot mode inputs at the last chip reset.
// - Boot-source 00 flash, 01 config pin, 10 option bit 7, 11 both.
// - Boot-source bits hold until system reset; writing one clears a bit.
// - Any boot-source bit set disables NMI and moves vectors to ROM base.
// - Sticky flags gather reset causes since power-on, LOW_VOLTAGE_DETECT or wakeup reset.
// - Writing one to a sticky flag clears it; writing zero leaves it.
// - Power-on sets sticky bit 7 and the low-voltage flag together.
// - Sticky bit 6 is set by a low level reset on the external pin.
// - Bus clock filter width applies only when run/wait select holds 01.
// - Bus clock filter state clears when filter is disabled or in stop.
// - Low-voltage flag also set by power-on and by enabled voltage trips.
`ifndef RESET_FILTER_MAP_VH
`define RESET_FILTER_MAP_VH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define IDX_RUN_WAIT_SEL   4'h4
`define IDX_PIN_WIDTH      4'h5
`define IDX_FORCE_BOOT     4'h6
`define IDX_BOOT_MODE      4'h7
`define IDX_STICKY_LOW     4'h8
`define IDX_IRQ_STATUS     4'hA
`define IDX_IRQ_MASK       4'hB

// ==========================================================================
// Field positions and implemented bit masks.
`define FORCE_LSB          1
`define MODE_LSB           1
`define STICKY_POR_BIT     7
`define STICKY_PIN_BIT     6
`define STICKY_LV_BIT      1
`define STICKY_IMPL        8'hC2
`define IRQ_PIN_BIT        0
`define IRQ_LV_BIT         1

// ==========================================================================
// Reset values and encodings.
`define PIN_WIDTH_RST      5'h00
`define FORCE_BOOT_RST     2'h0
`define RUN_WAIT_SEL_RST   2'h0
`define RUN_WAIT_SEL_BUS   2'h1
`define STICKY_RST         8'h82
`define IRQ_RST            2'h0
`define ROM_VECTOR_BASE    32'h1C000000
`define FLASH_VECTOR_BASE  32'h00000000

`endif

// ===== src/pin_filter.v
`timescale 1ns/1ps
`include "reset_filter_map.vh"

module pin_filter #(
  parameter CNT_W = 5
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             pin_in,
  input  wire             enable,
  input  wire [CNT_W-1:0] count_sel,
  output wire             level
);

  reg [CNT_W-1:0] cnt_ff;
  reg             level_ff;
  reg [CNT_W-1:0] nxt_cnt;
  reg             nxt_level;

  assign level = level_ff;

  // ========================================================================
  // Counting filter
  always @* begin
    nxt_cnt   = cnt_ff;
    nxt_level = level_ff;
    if (!enable) begin
      // Held transparent and empty so a later enable starts clean.
      nxt_cnt   = {CNT_W{1'b0}};
      nxt_level = pin_in;
    end else if (pin_in == level_ff) begin
      nxt_cnt = {CNT_W{1'b0}};
    end else if (cnt_ff == count_sel) begin
      nxt_level = pin_in;
      nxt_cnt   = {CNT_W{1'b0}};
    end else begin
      nxt_cnt = cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff   <= {CNT_W{1'b0}};
      level_ff <= 1'b1;
    end else begin
      cnt_ff   <= nxt_cnt;
      level_ff <= nxt_level;
    end
  end

endmodule

// ===== src/reset_filter_boot_status.v
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "reset_filter_map.vh"

module reset_filter_boot_status #(
  parameter ADDR_W = 6
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              reset_pin_b,
  input  wire              stop_mode,
  input  wire              sys_reset,
  input  wire              boot_config_pin,
  input  wire [7:0]        flash_option_byte,
  input  wire              lv_reset_event,
  input  wire              wakeup_reset_event,
  output wire              pin_reset_req,
  output wire              boot_from_rom,
  output wire              nmi_disable,
  output wire [31:0]       vector_table_base,
  output wire              irq
);

  // ========================================================================
  // Storage
  reg [31:0] prdata_ff;
  reg        pready_ff;
  reg        pslverr_ff;
  reg [1:0]  run_wait_sel_ff;
  reg [4:0]  pin_width_ff;
  reg [1:0]  force_boot_ff;
  reg [1:0]  boot_mode_ff;
  reg [7:0]  sticky_ff;
  reg [1:0]  irq_status_ff;
  reg [1:0]  irq_mask_ff;
  reg        irq_ff;
  reg        por_capture_ff;
  reg        pin_reset_req_ff;
  reg        boot_from_rom_ff;
  reg        nmi_disable_ff;
  reg [31:0] vector_base_ff;

  reg [31:0] nxt_prdata;
  reg        nxt_pready;
  reg        nxt_pslverr;
  reg [1:0]  nxt_boot_mode;
  reg [7:0]  nxt_sticky;
  reg [1:0]  nxt_irq_status;
  reg        nxt_pin_reset_req;
  reg        nxt_boot_from_rom;
  reg [31:0] rd_mux;
  reg        hit;

  wire [3:0] idx;
  wire       aligned;
  wire       setup;
  wire       wr_en;
  wire       filter_on;
  wire       filtered_level;
  wire       pin_event;
  wire       capture;
  wire [1:0] boot_capture;

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign irq               = irq_ff;
  assign pin_reset_req     = pin_reset_req_ff;
  assign boot_from_rom     = boot_from_rom_ff;
  assign nmi_disable       = nmi_disable_ff;
  assign vector_table_base = vector_base_ff;

  // ========================================================================
  // Bus decode
  // One word per register; low address bits must be zero and the index
  // must name a register, otherwise the access is unmapped.
  assign idx     = paddr[5:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & pready_ff;

  always @* begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    case (idx)
      `IDX_RUN_WAIT_SEL: begin
        rd_mux[1:0] = run_wait_sel_ff;
      end
      `IDX_PIN_WIDTH: begin
        rd_mux[4:0] = pin_width_ff;
      end
      `IDX_FORCE_BOOT: begin
        rd_mux[`FORCE_LSB+1:`FORCE_LSB] = force_boot_ff;
      end
      `IDX_BOOT_MODE: begin
        rd_mux[`MODE_LSB+1:`MODE_LSB] = boot_mode_ff;
      end
      `IDX_STICKY_LOW: begin
        rd_mux[7:0] = sticky_ff & `STICKY_IMPL;
      end
      `IDX_IRQ_STATUS: begin
        rd_mux[1:0] = irq_status_ff;
      end
      `IDX_IRQ_MASK: begin
        rd_mux[1:0] = irq_mask_ff;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (!aligned) begin
      hit    = 1'b0;
      rd_mux = 32'h00000000;
    end
  end

  // ========================================================================
  // Bus answer
  // The answer is prepared in the setup cycle, so every access completes
  // in its first access cycle with no wait state.
  always @* begin
    nxt_pready  = setup;
    nxt_pslverr = setup & ~hit;
    nxt_prdata  = prdata_ff;
    if (setup) begin
      nxt_prdata = pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // ========================================================================
  // Control registers
  // These are reset only by rst_b, which is the chip power-on reset; a
  // system reset on sys_reset leaves them untouched.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_wait_sel_ff <= `RUN_WAIT_SEL_RST;
      pin_width_ff    <= `PIN_WIDTH_RST;
      force_boot_ff   <= `FORCE_BOOT_RST;
      irq_mask_ff     <= `IRQ_RST;
    end else if (wr_en && aligned) begin
      case (idx)
        `IDX_RUN_WAIT_SEL: begin
          run_wait_sel_ff <= pwdata[1:0];
        end
        `IDX_PIN_WIDTH: begin
          pin_width_ff <= pwdata[4:0];
        end
        `IDX_FORCE_BOOT: begin
          force_boot_ff <= pwdata[`FORCE_LSB+1:`FORCE_LSB];
        end
        `IDX_IRQ_MASK: begin
          irq_mask_ff <= pwdata[1:0];
        end
        default: begin
          irq_mask_ff <= irq_mask_ff;
        end
      endcase
    end
  end

  // ========================================================================
  // Reset pin filter
  // Select 01 enables the bus clock filter; in stop mode the bus clock
  // filter is cleared and the pin passes unfiltered, as no low-power
  // filter lives in this block.
  assign filter_on = (run_wait_sel_ff == `RUN_WAIT_SEL_BUS) &
                     ~stop_mode;

  pin_filter #(
    .CNT_W (5)
  ) u_pin_filter (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_in    (reset_pin_b),
    .enable    (filter_on),
    .count_sel (pin_width_ff),
    .level     (filtered_level)
  );

  always @* begin
    if (filter_on) begin
      nxt_pin_reset_req = ~filtered_level;
    end else begin
      nxt_pin_reset_req = ~reset_pin_b;
    end
  end

  assign pin_event = nxt_pin_reset_req & ~pin_reset_req_ff;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_reset_req_ff <= 1'b0;
    end else begin
      pin_reset_req_ff <= nxt_pin_reset_req;
    end
  end

  // ========================================================================
  // Boot mode capture
  // The mode inputs cannot be loaded under the asynchronous reset, so the
  // first clock edge after power-on release performs the capture.
  assign capture      = por_capture_ff | sys_reset;
  assign boot_capture = {flash_option_byte[7] | force_boot_ff[1],
                         boot_config_pin | force_boot_ff[0]};

  always @* begin
    nxt_boot_mode     = boot_mode_ff;
    nxt_boot_from_rom = boot_from_rom_ff;
    if (wr_en && aligned && idx == `IDX_BOOT_MODE) begin
      nxt_boot_mode = boot_mode_ff &
                      ~pwdata[`MODE_LSB+1:`MODE_LSB];
    end
    if (capture) begin
      // A capture wins over a clear written in the same cycle.
      nxt_boot_mode     = boot_capture;
      nxt_boot_from_rom = |boot_capture;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      por_capture_ff   <= 1'b1;
      boot_mode_ff     <= 2'h0;
      boot_from_rom_ff <= 1'b0;
      nmi_disable_ff   <= 1'b0;
      vector_base_ff   <= `FLASH_VECTOR_BASE;
    end else begin
      por_capture_ff   <= 1'b0;
      boot_mode_ff     <= nxt_boot_mode;
      boot_from_rom_ff <= nxt_boot_from_rom;
      nmi_disable_ff   <= |nxt_boot_mode;
      if (|nxt_boot_mode) begin
        vector_base_ff <= `ROM_VECTOR_BASE;
      end else begin
        vector_base_ff <= `FLASH_VECTOR_BASE;
      end
    end
  end

  // ========================================================================
  // Sticky reset sources
  // Power-on leaves both the power-on and low-voltage flags set through the
  // reset value. Clears by software come first, then hardware sets, so an
  // event in the clearing cycle is kept.
  always @* begin
    nxt_sticky = sticky_ff;
    if (wr_en && aligned && idx == `IDX_STICKY_LOW) begin
      nxt_sticky = sticky_ff & ~pwdata[7:0];
    end
    if (wakeup_reset_event || lv_reset_event) begin
      nxt_sticky = 8'h00;
    end
    if (lv_reset_event) begin
      nxt_sticky[`STICKY_LV_BIT] = 1'b1;
    end
    if (pin_event) begin
      nxt_sticky[`STICKY_PIN_BIT] = 1'b1;
    end
    nxt_sticky = nxt_sticky & `STICKY_IMPL;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sticky_ff <= `STICKY_RST;
    end else begin
      sticky_ff <= nxt_sticky;
    end
  end

  // ========================================================================
  // Interrupt
  always @* begin
    nxt_irq_status = irq_status_ff;
    if (wr_en && aligned && idx == `IDX_IRQ_STATUS) begin
      nxt_irq_status = irq_status_ff & ~pwdata[1:0];
    end
    if (pin_event) begin
      nxt_irq_status[`IRQ_PIN_BIT] = 1'b1;
    end
    if (lv_reset_event) begin
      nxt_irq_status[`IRQ_LV_BIT] = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_ff <= `IRQ_RST;
      irq_ff        <= 1'b0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_ff        <= |(nxt_irq_status & irq_mask_ff);
    end
  end

endmodule

// ===== verification/reset_filter_boot_status_chk.sv
`timescale 1ns/1ps
module reset_filter_boot_status_chk (
  input wire        clk,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [5:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        reset_pin_b,
  input wire        stop_mode,
  input wire        sys_reset,
  input wire        pin_reset_req,
  input wire        boot_from_rom,
  input wire        nmi_disable,
  input wire [31:0] vector_table_base
);
  // ==========================================================
  // Bus and status relations.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire acc_rd = pready && !pwrite;

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (psel && !penable &&
    (paddr[5:2] == 4'h0 || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_width_rsvd: assert property (acc_rd && paddr[5:2] == 4'h5 |->
    prdata[7:5] == 3'h0)
    else $error("width reserved bits set");
  a_boot_rsvd: assert property (acc_rd && paddr[5:3] == 3'h3 |->
    prdata[7:3] == 5'h0 && !prdata[0])
    else $error("boot reserved bits set");
  a_vector_base: assert property (vector_table_base ==
    (nmi_disable ? 32'h1C000000 : 32'h0))
    else $error("vector base wrong");
  a_rom_boot: assert property ($rose(nmi_disable) |-> boot_from_rom)
    else $error("rom boot flag missing");
  a_stop_raw: assert property ($past(stop_mode) && $past(rst_b) |->
    pin_reset_req == !$past(reset_pin_b))
    else $error("pin not raw in stop");
  a_pin_held: assert property ($rose(pin_reset_req) |->
    !$past(reset_pin_b))
    else $error("pin request without low pin");
  a_mode_clear: assert property ($fell(nmi_disable) |->
    $past(sys_reset) || $past(sys_reset, 2) || $past(pwrite && penable)
    || $past(pwrite && penable, 2))
    else $error("boot source lost without cause");
endmodule

bind reset_filter_boot_status reset_filter_boot_status_chk chk_u (
  .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .reset_pin_b, .stop_mode, .sys_reset, .pin_reset_req,
  .boot_from_rom, .nmi_disable, .vector_table_base);

// ===== verification/reset_filter_boot_status_test.sv
`timescale 1ns/1ps
`include "reset_filter_map.vh"
module reset_filter_boot_status_test;
  // ==========================================================
  // Bench signals and reference model.
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    bad_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
  logic        clk = 0;
  logic        rst_b = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [5:0]  paddr = 0;
  logic [31:0] pwdata = 0;
  logic        pin_b = 1;
  logic        stop = 0;
  logic        sysr = 0;
  logic        cfg = 0;
  logic [7:0]  opt = 0;
  logic        lv_ev = 0;
  logic        wk_ev = 0;
  wire  [31:0] prdata;
  wire  [31:0] vbase;
  wire         pready;
  wire         pslverr;
  wire         req;
  wire         rom;
  wire         nmi;
  wire         irq;
  logic [7:0]  m [0:15];
  logic [31:0] r;
  logic        e;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          seed = 78770;
  int          w;

  reset_filter_boot_status dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_b(pin_b), .stop_mode(stop), .sys_reset(sysr),
    .boot_config_pin(cfg), .flash_option_byte(opt),
    .lv_reset_event(lv_ev), .wakeup_reset_event(wk_ev),
    .pin_reset_req(req), .boot_from_rom(rom), .nmi_disable(nmi),
    .vector_table_base(vbase), .irq(irq));

  always #25 clk = ~clk;

  // ==========================================================
  // Tasks.
  task apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    // Registered answer is read once settled, then the edge that takes it.
    do begin
      @(negedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    `CHK(k < 20, 1'b1)
    r = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 0;
    penable <= 0;
  endtask

  // The model follows each register's access kind on every write.
  task wr(input logic [3:0] i, input logic [31:0] d);
    apb(1, {i, 2'b00}, d);
    case (i)
      4'h4: m[i] = d[7:0] & 8'h03;
      4'h5: m[i] = d[7:0] & 8'h1F;
      4'h6: m[i] = d[7:0] & 8'h06;
      4'h7: m[i] = m[i] & ~(d[7:0] & 8'h06);
      4'h8: m[i] = m[i] & ~(d[7:0] & `STICKY_IMPL);
      4'hA: m[i] = m[i] & ~(d[7:0] & 8'h03);
      4'hB: m[i] = d[7:0] & 8'h03;
      default: ;
    endcase
  endtask

  task rd(input logic [3:0] i);
    apb(0, {i, 2'b00}, 32'h0);
    `CHK(r, {24'h0, m[i]})
  endtask

  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task sysrst;
    @(posedge clk);
    sysr <= 1;
    @(posedge clk);
    sysr <= 0;
    m[7] = {5'h0, opt[7] | m[6][2], cfg | m[6][1], 1'b0};
    cyc(2);
  endtask

  // Counts edges from the pin change until the request follows it.
  task meas(input logic lvl, input int want);
    int k;
    @(posedge clk);
    pin_b <= lvl;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (req !== ~lvl && k < 80);
    `CHK(k, want)
    if (!lvl) begin
      m[8] = m[8] | 8'h40;
      m[10] = m[10] | 8'h01;
    end
  endtask

  task chk_irq;
    cyc(2);
    `CHK(irq, |(m[10] & m[11]))
  endtask

  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #1000000;
    bad_count++;
    $display("ERROR %0t timeout", $time);
    give_verdict;
  end

  // ==========================================================
  // Main sequence.
  initial begin
    m = '{default: 8'h00};
    m[8] = `STICKY_RST;
    repeat (8) @(posedge clk);
    rst_b <= 1;
    for (int i = 4; i < 12; i++)
      if (i != 9) rd(4'(i));
    wr(8, 32'h0);
    rd(8);
    wr(8, 32'h80);
    rd(8);
    $display("reset values done");
    for (int i = 4; i < 12; i++)
      if (i < 7 || i == 11) begin
        wr(4'(i), 32'hFFFFFFFF);
        rd(4'(i));
      end
    apb(0, 6'h00, 32'h0);
    `CHK({e, r}, 33'h100000000)
    apb(1, 6'h15, 32'h0);
    `CHK(e, 1'b1)
    rd(5);
    $display("reserved bits done");
    for (int i = 0; i < 16; i++) begin
      wr(6, {29'h0, i[1:0], 1'b0});
      cfg <= i[2];
      opt <= {i[3], 7'($random(seed))};
      sysrst;
      rd(7);
      rd(6);
      rd(5);
      `CHK(rom, m[7] != 0)
      `CHK(nmi, m[7] != 0)
      `CHK(vbase, m[7] != 0 ? `ROM_VECTOR_BASE : `FLASH_VECTOR_BASE)
      wr(7, 32'h0);
      wr(7, 32'h2);
      rd(7);
      cyc(2);
      `CHK(nmi, m[7] != 0)
      wr(7, 32'h6);
      rd(7);
      `CHK(nmi, 1'b0)
    end
    wr(6, 32'h0);
    cfg <= 0;
    opt <= 0;
    sysrst;
    $display("boot mode done");
    wr(4, 32'h1);
    for (int j = 0; j < 3; j++) begin
      w = j == 0 ? 0 : j == 1 ? 31 : $unsigned($random(seed)) % 30 + 1;
      wr(5, w);
      // A low pulse one sample short of the width must be swallowed.
      if (w > 0) begin
        @(posedge clk);
        pin_b <= 0;
        repeat (w) @(posedge clk);
        pin_b <= 1;
        cyc(w + 4);
        `CHK(req, 1'b0)
      end
      meas(0, w + 2);
      meas(1, w + 2);
      rd(8);
    end
    stop <= 1;
    meas(0, 1);
    meas(1, 1);
    stop <= 0;
    wr(4, 32'h0);
    meas(0, 1);
    meas(1, 1);
    $display("pin filter done");
    wr(11, 32'h1);
    chk_irq;
    wr(11, 32'h0);
    chk_irq;
    wr(11, 32'h3);
    wr(10, 32'h1);
    chk_irq;
    @(posedge clk);
    lv_ev <= 1;
    @(posedge clk);
    lv_ev <= 0;
    m[8] = 8'h02;
    m[10] = m[10] | 8'h02;
    chk_irq;
    rd(8);
    rd(10);
    @(posedge clk);
    wk_ev <= 1;
    @(posedge clk);
    wk_ev <= 0;
    m[8] = 8'h00;
    rd(8);
    wr(10, 32'h2);
    chk_irq;
    $display("interrupts done");
    give_verdict;
  end
endmodule
